// ==== core/fts_status_bank.sv ====
// module: fifo status, trigger source enable and system mode registers
// assumes: the serial port gives one-cycle read/write strobes on clk_sys; the fifo,
//          event detectors and sleep logic share clk_sys
// Notes on behaviour
// - fifo driver on: address zero shows fifo status
// - bits 5..0 give stored sample count
// - bit 7 high while fifo overflowed
// - bit 6 high while count at/above watermark
// - in trigger mode bit 6 flags trigger
// - status read clears fifo interrupt bit
// - trigger mode: enabled event stops fifo collection
// - trigger bits 5,4: transient, orientation enables
// - trigger bits 3,2,1: pulse, freefall, magnitude
// - mode bits 1..0: standby, wake, sleep
// - trigger enables, gate error and elapsed count read zero after reset
// - gate error set on detect, cleared on empty
// - bits 6..2 count rate periods since error
// - mode zero selects data-ready status alias
// - overflow or watermark match sets fifo interrupt
// - mode register read clears auto-sleep bit
module fts_status_bank
  import fts_pkg::*;
#(
  parameter int CNT_W = 6
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // register port
  input  wire logic [7:0]       reg_addr,
  input  wire logic             reg_rd,
  input  wire logic             reg_wr,
  input  wire logic [7:0]       reg_wdata,
  output logic [7:0]            reg_rdata_q,
  // fifo side
  input  wire logic [1:0]       fifo_mode,
  input  wire logic [CNT_W-1:0] fifo_wmrk,
  input  wire logic [CNT_W-1:0] fifo_count,
  input  wire logic             fifo_ovf,
  input  wire logic             fifo_push,
  input  wire logic             fifo_gate_err,
  input  wire logic [7:0]       data_ready_status_register,
  output logic                  fifo_collect_stop,
  // event flags: [5] transient [4] orientation [3] pulse [2] freefall [1] magnitude
  input  wire logic [7:0]       event_flags,
  // system mode and tick
  input  wire logic [1:0]       sys_mode,
  input  wire logic             output_data_rate_tick,
  input  wire logic             aslp_event,
  // interrupt source bits
  output logic                  src_fifo_q,
  output logic                  src_aslp_q
);
  // ==========================================================
  // state
  logic [7:0]  trig_cfg_q;
  logic        trig_hit_q;
  logic        gerr_q;
  logic        wm_prev_q;
  logic        ovf_prev_q;
  logic [4:0]  gt_q;

  // ==========================================================
  // decode
  wire rd_status  = reg_rd && (reg_addr == FTS_ADDR_STATUS);
  wire rd_sysmode = reg_rd && (reg_addr == FTS_ADDR_SYSMODE);
  wire wr_trig    = reg_wr && (reg_addr == FTS_ADDR_TRIGCFG);
  wire trig_mode  = (fifo_mode == FTS_FMODE_TRIG);
  wire fifo_on    = (fifo_mode != FTS_FMODE_OFF);
  wire fifo_empty = (fifo_count == '0);
  wire wm_level   = (fifo_count >= fifo_wmrk);
  wire wm_match   = (fifo_count == fifo_wmrk) && !wm_prev_q;
  wire trig_fire  = trig_mode && |(event_flags & trig_cfg_q & FTS_TRIG_MASK);
  wire wm_flag    = trig_mode ? trig_hit_q : wm_level;
  // overflow counts once as it rises, so a status read can clear the bit while still full
  wire ovf_rise   = fifo_ovf && !ovf_prev_q;
  wire fifo_set   = ovf_rise || wm_match || ((wm_level || fifo_ovf) && fifo_push);

  // fifo status word: overflow, watermark/trigger, count
  wire [7:0] status_word = {fifo_ovf, wm_flag, fifo_count[5:0]};
  wire [7:0] sysmode_word = {gerr_q, gt_q, sys_mode};
  wire [7:0] rd_mux =
    (reg_addr == FTS_ADDR_STATUS)  ? (fifo_on ? status_word
                                              : data_ready_status_register) :
    (reg_addr == FTS_ADDR_TRIGCFG) ? trig_cfg_q :
    (reg_addr == FTS_ADDR_SYSMODE) ? sysmode_word : 8'h00;

  assign fifo_collect_stop = trig_mode && (trig_hit_q || trig_fire);

  // ==========================================================
  // trigger config register, only writable register of the bank
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      trig_cfg_q <= FTS_TRIGCFG_RST;
    end else if (wr_trig) begin
      trig_cfg_q <= reg_wdata & FTS_TRIG_MASK;
    end
  end

  // ==========================================================
  // trigger latch: held until trigger mode is left
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      trig_hit_q <= 1'b0;
    end else if (trig_fire) begin
      trig_hit_q <= 1'b1;
    end else if (!trig_mode) begin
      trig_hit_q <= 1'b0;
    end
  end

  // ==========================================================
  // gate error: set wins over empty so a same-cycle error is kept
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gerr_q <= 1'b0;
    end else if (fifo_gate_err) begin
      gerr_q <= 1'b1;
    end else if (fifo_empty) begin
      gerr_q <= 1'b0;
    end
  end

  fts_gate_timer #(.W(5)) u_gate_timer (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .gate_err  (gerr_q),
    .odr_tick  (output_data_rate_tick),
    .elapsed_q (gt_q)
  );

  // ==========================================================
  // interrupt source bits: hardware set beats read clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      src_fifo_q <= 1'b0;
      src_aslp_q <= 1'b0;
      wm_prev_q  <= 1'b0;
      ovf_prev_q <= 1'b0;
    end else begin
      wm_prev_q  <= (fifo_count == fifo_wmrk);
      ovf_prev_q <= fifo_ovf;
      src_fifo_q <= fifo_set || (src_fifo_q && !rd_status);
      src_aslp_q <= aslp_event || (src_aslp_q && !rd_sysmode);
    end
  end

  // ==========================================================
  // read data register, writes elsewhere ignored
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_q <= rd_mux;
    end
  end

  // ==========================================================
  // checks
  chk_status_count: assert property (@(posedge clk_sys) disable iff (rst)
    (rd_status && fifo_on) |=> (reg_rdata_q[5:0] == $past(fifo_count[5:0])))
    else $error("status count mismatch");
  chk_status_ovf: assert property (@(posedge clk_sys) disable iff (rst)
    (rd_status && fifo_on) |=> (reg_rdata_q[7] == $past(fifo_ovf)))
    else $error("overflow bit mismatch");
  chk_wmrk_level: assert property (@(posedge clk_sys) disable iff (rst)
    (rd_status && fifo_on && !trig_mode) |=> (reg_rdata_q[6] == $past(wm_level)))
    else $error("watermark bit mismatch");
  chk_alias_select: assert property (@(posedge clk_sys) disable iff (rst)
    (rd_status && !fifo_on) |=> (reg_rdata_q == $past(data_ready_status_register)))
    else $error("data ready alias wrong");
  chk_fifo_clear: assert property (@(posedge clk_sys) disable iff (rst)
    (rd_status && !fifo_set) |=> !src_fifo_q)
    else $error("fifo source not cleared");
  chk_aslp_clear: assert property (@(posedge clk_sys) disable iff (rst)
    (rd_sysmode && !aslp_event) |=> !src_aslp_q)
    else $error("sleep source not cleared");
  chk_trig_stop: assert property (@(posedge clk_sys) disable iff (rst)
    (trig_fire ##1 trig_mode) |-> fifo_collect_stop)
    else $error("trigger did not stop fifo");
  chk_gerr_clear: assert property (@(posedge clk_sys) disable iff (rst)
    (fifo_empty && !fifo_gate_err) |=> (!gerr_q ##1 gt_q == 5'h00))
    else $error("gate error not cleared");
  chk_trig_write: assert property (@(posedge clk_sys) disable iff (rst)
    !wr_trig |=> (trig_cfg_q == $past(trig_cfg_q)))
    else $error("trigger config changed without write");

  // ==========================================================
  // checks on read fields, enables and interrupt sources
  chk_trig_flag: assert property (@(posedge clk_sys) disable iff (rst)
    (rd_status && fifo_on && trig_mode) |=> (reg_rdata_q[6] == $past(trig_hit_q)))
    else $error("trigger flag bit mismatch");
  chk_cfg_enables: assert property (@(posedge clk_sys) disable iff (rst)
    wr_trig |=> (trig_cfg_q[5:1] == $past(reg_wdata[5:1])))
    else $error("trigger enables not written");
  chk_mode_field: assert property (@(posedge clk_sys) disable iff (rst)
    rd_sysmode |=> (reg_rdata_q[1:0] == $past(sys_mode)))
    else $error("system mode field mismatch");
  chk_gerr_bit: assert property (@(posedge clk_sys) disable iff (rst)
    rd_sysmode |=> (reg_rdata_q[7] == $past(gerr_q)))
    else $error("gate error bit mismatch");
  chk_gerr_set: assert property (@(posedge clk_sys) disable iff (rst)
    fifo_gate_err |=> gerr_q)
    else $error("gate error not set");
  chk_gt_count: assert property (@(posedge clk_sys) disable iff (rst)
    (gerr_q && output_data_rate_tick && (gt_q != FTS_GT_MAX)) |=> (gt_q == $past(gt_q) + 5'h01))
    else $error("elapsed count did not advance");
  chk_gt_idle: assert property (@(posedge clk_sys) disable iff (rst)
    !gerr_q |=> (gt_q == FTS_GT_RST))
    else $error("elapsed count not zero");
  chk_ovf_set: assert property (@(posedge clk_sys) disable iff (rst)
    ovf_rise |=> src_fifo_q)
    else $error("overflow did not set fifo source");
  chk_wmatch_set: assert property (@(posedge clk_sys) disable iff (rst)
    wm_match |=> src_fifo_q)
    else $error("watermark match did not set fifo source");
  chk_push_set: assert property (@(posedge clk_sys) disable iff (rst)
    (fifo_push && (wm_level || fifo_ovf)) |=> src_fifo_q)
    else $error("new sample did not set fifo source");
  chk_aslp_set: assert property (@(posedge clk_sys) disable iff (rst)
    aslp_event |=> src_aslp_q)
    else $error("sleep event did not set source");
endmodule : fts_status_bank

// ==== core/fts_pkg.sv ====
// package: register map, field positions and reset values of the fifo status bank
// assumes: a single 40 MHz system clock and an 8-bit register port outside this block
package fts_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] FTS_ADDR_STATUS  = 8'h00;
  localparam logic [7:0] FTS_ADDR_TRIGCFG = 8'h0a;
  localparam logic [7:0] FTS_ADDR_SYSMODE = 8'h0b;
  // ==========================================================
  // field positions
  localparam int FTS_ST_OVF_BIT  = 7;
  localparam int FTS_ST_WMRK_BIT = 6;
  localparam int FTS_SM_GERR_BIT = 7;
  localparam logic [7:0] FTS_TRIG_MASK = 8'h3e; // bits 5..1 writable
  // ==========================================================
  // reset values and codes
  localparam logic [7:0] FTS_TRIGCFG_RST = 8'h00;
  localparam logic [4:0] FTS_GT_RST      = 5'h00;
  localparam logic [4:0] FTS_GT_MAX      = 5'h1f;
  localparam logic [1:0] FTS_FMODE_OFF   = 2'h0;
  localparam logic [1:0] FTS_FMODE_TRIG  = 2'h3;
  localparam int         FTS_DEPTH       = 32;
  typedef enum logic [1:0] {
    FTS_MODE_STANDBY = 2'b00,
    FTS_MODE_WAKE    = 2'b01,
    FTS_MODE_SLEEP   = 2'b10
  } fts_mode_e;
endpackage : fts_pkg

// ==== core/fts_gate_timer.sv ====
// module: elapsed output-data-rate counter for the fifo gate error
// assumes: odr_tick is a one-cycle pulse on clk_sys
module fts_gate_timer #(
  parameter int W = 5
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // control
  input  wire logic         gate_err,
  input  wire logic         odr_tick,
  // count
  output logic [W-1:0]      elapsed_q
);
  import fts_pkg::*;
  logic [W-1:0] elapsed_d;
  wire          at_max = &elapsed_q;

  // saturate instead of wrapping so a long-stale error never looks fresh
  assign elapsed_d = !gate_err ? '0 :
                     (odr_tick && !at_max) ? elapsed_q + 1'b1 : elapsed_q;

  // ==========================================================
  // counter register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      elapsed_q <= '0;
    end else begin
      elapsed_q <= elapsed_d;
    end
  end

  chk_gt_sat: assert property (@(posedge clk_sys) disable iff (rst)
    (gate_err && at_max) |=> (elapsed_q == {W{1'b1}}))
    else $error("gate timer wrapped");
endmodule : fts_gate_timer

// ==== testbench/fts_host_model.sv ====
// file: host model that reads and writes the status bank registers
// assumes: strobes are launched 1 ns after a rising edge of clk_sys
module fts_host_model (
  // clock
  input  wire logic       clk_sys,
  // register port
  output logic [7:0]      reg_addr,
  output logic            reg_rd,
  output logic            reg_wr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // =======
  // idle port
  initial begin
    reg_addr  = 8'hff;
    reg_rd    = 1'b0;
    reg_wr    = 1'b0;
    reg_wdata = 8'hff;
  end
  // =======
  // one-cycle strobe held up to the taking edge; idle lines inverted so stale values never match
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge clk_sys);
    #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = wr;
    reg_rd    = ~wr;
    @(posedge clk_sys);
    #1;
    reg_rd    = 1'b0;
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
    q         = reg_rdata_q;
  endtask : access
endmodule : fts_host_model

// ==== testbench/test_fifo_trigger_sysmode_status.sv ====
// file: self-checking bench for the fifo status bank
// assumes: fts_pkg compiled first; the host model drives the register port
module test_fifo_trigger_sysmode_status;
  timeunit 1ns;
  timeprecision 1ps;
  import fts_pkg::*;
  logic       clk_sys, rst, reg_rd, reg_wr, fifo_ovf, fifo_push, fifo_gate_err;
  logic       fifo_collect_stop, output_data_rate_tick, aslp_event, src_fifo_q, src_aslp_q;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_q, data_ready_status_register, event_flags, q;
  logic [5:0] fifo_wmrk, fifo_count;
  logic [1:0] fifo_mode, sys_mode;
  int         mismatches, n_tests;
  fts_status_bank fts_status_bank_i (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .fifo_mode(fifo_mode), .fifo_wmrk(fifo_wmrk), .fifo_count(fifo_count),
    .fifo_ovf(fifo_ovf), .fifo_push(fifo_push), .fifo_gate_err(fifo_gate_err),
    .data_ready_status_register(data_ready_status_register),
    .fifo_collect_stop(fifo_collect_stop), .event_flags(event_flags), .sys_mode(sys_mode),
    .output_data_rate_tick(output_data_rate_tick), .aslp_event(aslp_event),
    .src_fifo_q(src_fifo_q), .src_aslp_q(src_aslp_q));
  fts_host_model fts_host_model_i (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q));
  // =======
  // clock and watchdog; a hang counts as a mismatch
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    #2_000_000;
    mismatches++;
    $display("MISMATCH watchdog expected finish seen hang");
    complete_run();
  end
  // =======
  // shared helpers
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    fts_host_model_i.access(1'b0, a, 8'h00, q);
    chk($sformatf("reg %h", a), e, q);
  endtask : rchk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    fts_host_model_i.access(1'b1, a, d, q);
  endtask : wr
  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
    step(1);
  endtask : pulse
  // =======
  // scenarios
  task automatic t_reset(input int n);
    rst = 1'b1;
    step(n);
    rst = 1'b0;
    chk("src_fifo", 8'h00, {7'h00, src_fifo_q});
    chk("src_aslp", 8'h00, {7'h00, src_aslp_q});
    rchk(FTS_ADDR_STATUS, 8'h00);
    rchk(FTS_ADDR_TRIGCFG, FTS_TRIGCFG_RST);
    rchk(FTS_ADDR_SYSMODE, 8'h00);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_status;
    fifo_count = 6'h20;
    fifo_ovf   = 1'b1;
    step(2);
    chk("src_fifo", 8'h01, {7'h00, src_fifo_q});
    rchk(FTS_ADDR_STATUS, 8'he0);
    chk("src_fifo", 8'h00, {7'h00, src_fifo_q});
    fifo_ovf   = 1'b0;
    fifo_count = 6'h13;
    step(1);
    rchk(FTS_ADDR_STATUS, 8'h13);
    chk("src_fifo", 8'h00, {7'h00, src_fifo_q});
    fifo_count = 6'h16;
    step(1);
    pulse(fifo_push);
    chk("src_fifo", 8'h01, {7'h00, src_fifo_q});
    fifo_mode = FTS_FMODE_OFF;
    rchk(FTS_ADDR_STATUS, 8'h5a);
    fifo_mode  = 2'h1;
    fifo_count = 6'h13;
    step(1);
    fifo_count = 6'h14;
    step(1);
    chk("src_fifo", 8'h01, {7'h00, src_fifo_q});
    fifo_count = 6'h13;
    $display("t_status done");
  endtask : t_status
  task automatic t_trig;
    wr(FTS_ADDR_TRIGCFG, 8'hff);
    rchk(FTS_ADDR_TRIGCFG, 8'h3e);
    wr(FTS_ADDR_STATUS, 8'hff);
    wr(FTS_ADDR_SYSMODE, 8'hff);
    rchk(FTS_ADDR_SYSMODE, 8'h00);
    for (int b = 1; b <= 5; b++) begin
      fifo_mode = 2'h1;
      wr(FTS_ADDR_TRIGCFG, 8'h01 << b);
      event_flags = 8'h3e & ~(8'h01 << b);
      fifo_mode   = FTS_FMODE_TRIG;
      step(1);
      chk("stop", 8'h00, {7'h00, fifo_collect_stop});
      event_flags = 8'h01 << b;
      step(1);
      chk("stop", 8'h01, {7'h00, fifo_collect_stop});
    end
    rchk(FTS_ADDR_STATUS, 8'h53);
    event_flags = 8'h00;
    fifo_mode   = 2'h1;
    $display("t_trig done");
  endtask : t_trig
  task automatic t_sysmode;
    sys_mode   = FTS_MODE_SLEEP;
    fifo_count = 6'h05;
    pulse(fifo_gate_err);
    repeat (3) pulse(output_data_rate_tick);
    rchk(FTS_ADDR_SYSMODE, 8'h8e);
    repeat (40) pulse(output_data_rate_tick);
    rchk(FTS_ADDR_SYSMODE, 8'hfe);
    fifo_count = 6'h00;
    step(2);
    rchk(FTS_ADDR_SYSMODE, 8'h02);
    sys_mode = FTS_MODE_WAKE;
    rchk(FTS_ADDR_SYSMODE, 8'h01);
    sys_mode = FTS_MODE_STANDBY;
    pulse(aslp_event);
    chk("src_aslp", 8'h01, {7'h00, src_aslp_q});
    rchk(FTS_ADDR_SYSMODE, 8'h00);
    chk("src_aslp", 8'h00, {7'h00, src_aslp_q});
    $display("t_sysmode done");
  endtask : t_sysmode
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run
  // =======
  // main sequence
  initial begin
    {fifo_ovf, fifo_push, fifo_gate_err, output_data_rate_tick, aslp_event} = 5'h00;
    {fifo_mode, sys_mode, fifo_count, fifo_wmrk} = {2'h1, 2'h0, 6'h00, 6'h14};
    data_ready_status_register = 8'h5a;
    event_flags = 8'h00;
    t_reset(8);
    t_status();
    t_trig();
    t_sysmode();
    t_reset(2);
    complete_run();
  end
endmodule : test_fifo_trigger_sysmode_status
